// ---- mid_pkg.sv ----
// Purpose: shared constants, encodings and carriers of the misc instruction decoder
// Assumes: 48-bit instruction words, 24-bit program addresses, 32-bit data
// Notes: opcode values and field positions below are fixed for this core

package mid_pkg;

    // ------------------------------------------------------------------
    // instruction type codes, top eight opcode bits
    // ------------------------------------------------------------------
    localparam logic [7:0] MID_OPC_SHIFT_IMM = 8'h06;
    localparam logic [7:0] MID_OPC_BRANCH = 8'h08;
    localparam logic [7:0] MID_OPC_RET_INT = 8'h0a;
    localparam logic [7:0] MID_OPC_BITOP = 8'h12;
    localparam logic [7:0] MID_OPC_NOP = 8'h15;
    localparam logic [7:0] MID_OPC_WAIT = 8'h16;
    localparam logic [7:0] MID_OPC_FRAME = 8'h19;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int MID_TYPE_HI = 47;
    localparam int MID_TYPE_LO = 40;
    localparam int MID_SUB_HI = 36;
    localparam int MID_SUB_LO = 34;
    localparam int MID_WAIT_SEL_POS = 39;
    localparam int MID_DLY_POS = 39;
    localparam int MID_ABORT_POS = 38;
    localparam int MID_CLRINT_POS = 37;
    localparam int MID_BSEL_HI = 39;
    localparam int MID_BSEL_LO = 37;
    localparam int MID_SREG_HI = 36;
    localparam int MID_SREG_LO = 33;
    localparam int MID_EXT_HI = 35;
    localparam int MID_EXT_LO = 32;
    localparam int MID_DATA_HI = 7;
    localparam int MID_DATA_LO = 0;
    localparam int MID_ADDR_HI = 23;

    // frame instruction sub-codes in bits 36..34
    localparam logic [2:0] MID_SUB_CJ_DIRECT = 3'h0;
    localparam logic [2:0] MID_SUB_CJ_REL = 3'h1;
    localparam logic [2:0] MID_SUB_RFRAME = 3'h2;

    // ------------------------------------------------------------------
    // register map (byte addresses) and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] MID_ADR_CTRL = 8'h00;
    localparam logic [7:0] MID_ADR_STATUS = 8'h04;
    localparam logic [7:0] MID_ADR_FRAME_INDEX = 8'h08;
    localparam logic [7:0] MID_ADR_STACK_INDEX = 8'h0c;
    localparam logic [7:0] MID_ADR_X_DATA_REG_TWO = 8'h10;
    localparam logic [7:0] MID_ADR_Y_DATA_REG_TWO = 8'h14;
    localparam logic [7:0] MID_ADR_PC = 8'h18;
    localparam logic [23:0] MID_PC_RESET = 24'h000000;
    localparam logic [23:0] MID_IRQ_VECTOR = 24'h000040;
    localparam logic [31:0] MID_INDEX_RESET = 32'h00000000;
    localparam logic [1:0] MID_DLY_SLOTS = 2'h2;

    // ------------------------------------------------------------------
    // enumerations and carriers
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MID_SZ_48 = 2'b00,
        MID_SZ_32 = 2'b01,
        MID_SZ_16 = 2'b10
    } mid_size_t;

    typedef enum logic [2:0] {
        MID_BSEL_SET = 3'b000,
        MID_BSEL_CLR = 3'b001,
        MID_BSEL_TGL = 3'b010,
        MID_BSEL_TST = 3'b100,
        MID_BSEL_XOR = 3'b101
    } mid_bsel_t;

    typedef enum logic [1:0] {
        MID_ST_RUN = 2'b00,
        MID_ST_WAIT = 2'b01,
        MID_ST_EMU = 2'b10,
        MID_ST_FRAME = 2'b11
    } mid_fsm_t;

    typedef struct packed {
        logic valid;
        logic legal;
        mid_bsel_t op;
        logic [3:0] sreg;
        logic [31:0] mask;
    } mid_bitop_t;

endpackage

// ---- mid_align.sv ----
// Purpose: aligns fetched words to the top of the 48-bit decode word
// Assumes: short encodings sit in the low bits of the fetched word
// Notes: pure combinational, also yields the fetch address step

module mid_align (
    input wire logic [47:0] word_i,
    input wire logic short_space_i,
    input wire logic [1:0] size_i,
    output logic [47:0] aligned_o,
    output logic [1:0] step_o
);

    // ------------------------------------------------------------------
    // alignment
    // ------------------------------------------------------------------
    // normal space is always full width; an illegal size code is read as 48
    always_comb
    begin
        aligned_o = word_i;
        step_o = 2'h1;
        if (short_space_i)
        begin
            step_o = 2'h3;
            if (size_i == mid_pkg::MID_SZ_32)
            begin
                aligned_o = {word_i[31:0], 16'h0000};
                step_o = 2'h2;
            end
            else if (size_i == mid_pkg::MID_SZ_16)
            begin
                aligned_o = {word_i[15:0], 32'h00000000};
                step_o = 2'h1;
            end
        end
    end

endmodule

// ---- mid_bitop_dec.sv ----
// Purpose: decodes the bit manipulation select field
// Assumes: word is already aligned to bit 47
// Notes: codes 011, 110 and 111 are flagged as not legal

module mid_bitop_dec (
    input wire logic [47:0] word_i,
    input wire logic hit_i,
    output mid_pkg::mid_bitop_t bitop_o
);

    // ------------------------------------------------------------------
    // select field decode
    // ------------------------------------------------------------------
    always_comb
    begin
        bitop_o.valid = hit_i;
        bitop_o.sreg = word_i[mid_pkg::MID_SREG_HI:mid_pkg::MID_SREG_LO];
        bitop_o.mask = word_i[31:0];
        bitop_o.legal = 1'b1;
        case (word_i[mid_pkg::MID_BSEL_HI:mid_pkg::MID_BSEL_LO])
            3'b000: bitop_o.op = mid_pkg::MID_BSEL_SET;
            3'b001: bitop_o.op = mid_pkg::MID_BSEL_CLR;
            3'b010: bitop_o.op = mid_pkg::MID_BSEL_TGL;
            3'b100: bitop_o.op = mid_pkg::MID_BSEL_TST;
            3'b101: bitop_o.op = mid_pkg::MID_BSEL_XOR;
            default:
            begin
                bitop_o.op = mid_pkg::MID_BSEL_SET;
                bitop_o.legal = 1'b0;
            end
        endcase
    end

endmodule

// ---- mid_core.sv ----
// Purpose: decode and execute of the miscellaneous instruction group
// Assumes: fetch unit presents one instruction per valid/ready handshake
// Notes: registers reached over classic wishbone, one aligned word each

module mid_core (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // fetch side
    input wire logic instr_valid_i,
    output logic instr_ready_o,
    input wire logic [47:0] instr_word_i,
    input wire logic instr_short_space_i,
    input wire logic [1:0] instr_size_i,
    input wire logic cond_true_i,
    input wire logic irq_i,
    output logic [23:0] fetch_addr_o,
    // sequencer and data memory side
    output logic jump_o,
    output logic loop_pop_o,
    output logic pcstk_pop_o,
    output logic clr_int_o,
    output logic irq_ack_o,
    output logic low_power_o,
    output logic emu_space_o,
    output logic [11:0] imm12_o,
    output logic imm_valid_o,
    output mid_pkg::mid_bitop_t bitop_o,
    output logic dm_rd_o,
    output logic [31:0] dm_addr_o,
    input wire logic [31:0] dm_rdata_i,
    input wire logic dm_rvalid_i
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        mid_pkg::mid_fsm_t fsm;
        logic [23:0] pc;
        logic [23:0] ret_pc;
        logic [1:0] dly_cnt;
        logic [23:0] dly_target;
        logic dual;
        logic [31:0] frame_index;
        logic [31:0] stack_index;
        logic [31:0] x_data_reg_two;
        logic [31:0] y_data_reg_two;
        logic ack;
        logic [31:0] rdata;
        logic jump;
        logic loop_pop;
        logic pcstk_pop;
        logic clr_int;
        logic irq_ack;
        logic [11:0] imm12;
        logic imm_valid;
        mid_pkg::mid_bitop_t bitop;
        logic dm_rd;
        logic [31:0] dm_addr;
    } mid_core_state_t;

    mid_core_state_t state_reg;
    mid_core_state_t state_next;

    logic [47:0] word;
    logic [1:0] step;
    logic [7:0] opc;
    logic [2:0] sub;
    logic accept;
    logic wb_req;
    logic [31:0] wmask;
    logic [31:0] rd_mux;
    mid_pkg::mid_bitop_t bitop_dec;

    // ------------------------------------------------------------------
    // alignment and field decode
    // ------------------------------------------------------------------
    mid_align u_align (
        .word_i(instr_word_i),
        .short_space_i(instr_short_space_i),
        .size_i(instr_size_i),
        .aligned_o(word),
        .step_o(step)
    );

    // type from the top byte, sub-code from bits 36..34
    assign opc = word[mid_pkg::MID_TYPE_HI:mid_pkg::MID_TYPE_LO];
    assign sub = word[mid_pkg::MID_SUB_HI:mid_pkg::MID_SUB_LO];

    mid_bitop_dec u_bitop (
        .word_i(word),
        .hit_i(opc == mid_pkg::MID_OPC_BITOP),
        .bitop_o(bitop_dec)
    );

    // ------------------------------------------------------------------
    // handshake and bus helpers
    // ------------------------------------------------------------------
    // no intake while asleep, restoring the frame, or taking an interrupt
    assign instr_ready_o = ((state_reg.fsm == mid_pkg::MID_ST_RUN) && !irq_i)
        || (state_reg.fsm == mid_pkg::MID_ST_EMU);
    assign accept = instr_valid_i && instr_ready_o;
    assign wb_req = wb_cyc_i && wb_stb_i && !state_reg.ack;

    // byte lane mask from the selects
    for (genvar b = 0; b < 4; b++)
    begin : g_lane
        assign wmask[8*b+7:8*b] = {8{wb_sel_i[b]}};
    end

    // read mux, unmapped addresses read zero
    always_comb
    begin
        rd_mux = 32'h00000000;
        case (wb_adr_i)
            mid_pkg::MID_ADR_CTRL: rd_mux = {31'h00000000, state_reg.dual};
            mid_pkg::MID_ADR_STATUS: rd_mux = {30'h00000000, state_reg.fsm};
            mid_pkg::MID_ADR_FRAME_INDEX: rd_mux = state_reg.frame_index;
            mid_pkg::MID_ADR_STACK_INDEX: rd_mux = state_reg.stack_index;
            mid_pkg::MID_ADR_X_DATA_REG_TWO: rd_mux = state_reg.x_data_reg_two;
            mid_pkg::MID_ADR_Y_DATA_REG_TWO: rd_mux = state_reg.y_data_reg_two;
            mid_pkg::MID_ADR_PC: rd_mux = {8'h00, state_reg.pc};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        state_next.ack = 1'b0;
        state_next.jump = 1'b0;
        state_next.loop_pop = 1'b0;
        state_next.pcstk_pop = 1'b0;
        state_next.clr_int = 1'b0;
        state_next.irq_ack = 1'b0;
        state_next.imm_valid = 1'b0;
        state_next.bitop.valid = 1'b0;
        state_next.dm_rd = 1'b0;

        // bus access first, so core updates in the same cycle win
        if (wb_req)
        begin
            state_next.ack = 1'b1;
            state_next.rdata = rd_mux;
            if (wb_we_i)
            begin
                case (wb_adr_i)
                    mid_pkg::MID_ADR_CTRL:
                        if (wb_sel_i[0])
                            state_next.dual = wb_dat_i[0];
                    mid_pkg::MID_ADR_FRAME_INDEX:
                        state_next.frame_index = (state_reg.frame_index & ~wmask)
                            | (wb_dat_i & wmask);
                    mid_pkg::MID_ADR_STACK_INDEX:
                        state_next.stack_index = (state_reg.stack_index & ~wmask)
                            | (wb_dat_i & wmask);
                    default:
                        state_next.dual = state_reg.dual;
                endcase
            end
        end

        // sequencing that does not consume an instruction
        unique case (state_reg.fsm)
            mid_pkg::MID_ST_RUN:
                if (irq_i)
                begin
                    state_next.ret_pc = state_reg.pc;
                    state_next.pc = mid_pkg::MID_IRQ_VECTOR;
                    state_next.irq_ack = 1'b1;
                end
            mid_pkg::MID_ST_WAIT:
                // pc already points past the wait instruction
                if (irq_i)
                begin
                    state_next.ret_pc = state_reg.pc;
                    state_next.pc = mid_pkg::MID_IRQ_VECTOR;
                    state_next.irq_ack = 1'b1;
                    state_next.fsm = mid_pkg::MID_ST_RUN;
                end
            mid_pkg::MID_ST_EMU:
                state_next.fsm = mid_pkg::MID_ST_EMU;
            mid_pkg::MID_ST_FRAME:
                if (dm_rvalid_i)
                begin
                    state_next.frame_index = dm_rdata_i;
                    state_next.fsm = mid_pkg::MID_ST_RUN;
                end
        endcase

        // execute an accepted instruction
        if (accept)
        begin
            // sequential address, or the pending delayed target
            state_next.pc = state_reg.pc + 24'(step);
            if (state_reg.dly_cnt != 2'h0)
            begin
                state_next.dly_cnt = state_reg.dly_cnt - 2'h1;
                if (state_reg.dly_cnt == 2'h1)
                    state_next.pc = state_reg.dly_target;
            end
            case (opc)
                mid_pkg::MID_OPC_NOP:
                    state_next.fsm = state_reg.fsm;
                mid_pkg::MID_OPC_WAIT:
                    if (word[mid_pkg::MID_WAIT_SEL_POS])
                        state_next.fsm = mid_pkg::MID_ST_WAIT;
                    else
                        state_next.fsm = mid_pkg::MID_ST_EMU;
                mid_pkg::MID_OPC_RET_INT:
                begin
                    if (state_reg.fsm == mid_pkg::MID_ST_EMU)
                        state_next.fsm = mid_pkg::MID_ST_RUN;
                    else
                        state_next.pc = state_reg.ret_pc;
                    state_next.clr_int = word[mid_pkg::MID_CLRINT_POS];
                end
                mid_pkg::MID_OPC_BRANCH:
                    if (cond_true_i)
                    begin
                        state_next.jump = 1'b1;
                        if (word[mid_pkg::MID_DLY_POS])
                        begin
                            state_next.dly_cnt = mid_pkg::MID_DLY_SLOTS;
                            state_next.dly_target = word[mid_pkg::MID_ADDR_HI:0];
                        end
                        else
                            state_next.pc = word[mid_pkg::MID_ADDR_HI:0];
                        state_next.loop_pop = word[mid_pkg::MID_ABORT_POS];
                        state_next.pcstk_pop = word[mid_pkg::MID_ABORT_POS];
                        state_next.clr_int = word[mid_pkg::MID_CLRINT_POS];
                    end
                mid_pkg::MID_OPC_FRAME:
                    // the 16-bit short form only carries the restore
                    if (sub == mid_pkg::MID_SUB_RFRAME ||
                        (instr_short_space_i && instr_size_i == mid_pkg::MID_SZ_16))
                    begin
                        state_next.stack_index = state_reg.frame_index;
                        state_next.dm_rd = 1'b1;
                        state_next.dm_addr = state_reg.frame_index + 32'h00000000;
                        state_next.fsm = mid_pkg::MID_ST_FRAME;
                    end
                    else
                    begin
                        state_next.jump = 1'b1;
                        state_next.dly_cnt = mid_pkg::MID_DLY_SLOTS;
                        // 24-bit add wraps, so a signed offset needs no extension
                        if (sub == mid_pkg::MID_SUB_CJ_REL)
                            state_next.dly_target = state_reg.pc
                                + word[mid_pkg::MID_ADDR_HI:0];
                        else
                            state_next.dly_target = word[mid_pkg::MID_ADDR_HI:0];
                        state_next.x_data_reg_two = state_reg.frame_index;
                        if (state_reg.dual)
                            state_next.y_data_reg_two = state_reg.frame_index;
                        state_next.frame_index = state_reg.stack_index;
                    end
                mid_pkg::MID_OPC_SHIFT_IMM:
                begin
                    state_next.imm12 = {word[mid_pkg::MID_EXT_HI:mid_pkg::MID_EXT_LO],
                        word[mid_pkg::MID_DATA_HI:mid_pkg::MID_DATA_LO]};
                    state_next.imm_valid = 1'b1;
                end
                mid_pkg::MID_OPC_BITOP:
                    state_next.bitop = bitop_dec;
                default:
                    state_next.fsm = state_reg.fsm;
            endcase
            // emulator-fed instructions leave the user program address alone
            if (state_reg.fsm == mid_pkg::MID_ST_EMU)
            begin
                state_next.pc = state_reg.pc;
                state_next.dly_cnt = state_reg.dly_cnt;
            end
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= '0;
            state_reg.fsm <= mid_pkg::MID_ST_RUN;
            state_reg.pc <= mid_pkg::MID_PC_RESET;
            state_reg.ret_pc <= mid_pkg::MID_PC_RESET;
            state_reg.frame_index <= mid_pkg::MID_INDEX_RESET;
            state_reg.stack_index <= mid_pkg::MID_INDEX_RESET;
        end
        else
            state_reg <= state_next;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign wb_dat_o = state_reg.rdata;
    assign wb_ack_o = state_reg.ack;
    assign fetch_addr_o = state_reg.pc;
    assign jump_o = state_reg.jump;
    assign loop_pop_o = state_reg.loop_pop;
    assign pcstk_pop_o = state_reg.pcstk_pop;
    assign clr_int_o = state_reg.clr_int;
    assign irq_ack_o = state_reg.irq_ack;
    assign low_power_o = (state_reg.fsm == mid_pkg::MID_ST_WAIT);
    assign emu_space_o = (state_reg.fsm == mid_pkg::MID_ST_EMU);
    assign imm12_o = state_reg.imm12;
    assign imm_valid_o = state_reg.imm_valid;
    assign bitop_o = state_reg.bitop;
    assign dm_rd_o = state_reg.dm_rd;
    assign dm_addr_o = state_reg.dm_addr;

endmodule

// ---- mid_core_props.sv ----
// Purpose: port checks of the misc decoder
// Assumes: decode checks look at normal word space only
// Notes: short space decode is judged by the bench
module mid_core_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic instr_valid_i,
    input wire logic instr_ready_o,
    input wire logic [47:0] instr_word_i,
    input wire logic instr_short_space_i,
    input wire logic cond_true_i,
    input wire logic irq_i,
    input wire logic [23:0] fetch_addr_o,
    input wire logic jump_o,
    input wire logic loop_pop_o,
    input wire logic pcstk_pop_o,
    input wire logic clr_int_o,
    input wire logic irq_ack_o,
    input wire logic low_power_o,
    input wire logic emu_space_o,
    input wire logic [11:0] imm12_o,
    input wire logic imm_valid_o,
    input wire mid_pkg::mid_bitop_t bitop_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------
    // accepted full-width word
    // ----------------
    logic acc;
    logic [47:0] w;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    assign acc = instr_valid_i & instr_ready_o & ~instr_short_space_i;
    assign w = instr_word_i;
    // effects land one cycle after the accepting edge
    property p_wait;
        acc && w[47:40] == 8'h16 && w[39] |=> low_power_o && !instr_ready_o;
    endproperty
    a_wait: assert property (p_wait) else $error("no low power");
    property p_wake; low_power_o && irq_i |=> !low_power_o && irq_ack_o; endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_emu; acc && w[47:40] == 8'h16 && !w[39] |=> emu_space_o && !low_power_o; endproperty
    a_emu: assert property (p_emu) else $error("no halt");
    property p_jmp; acc && w[47:40] == 8'h19 && w[36:35] == 2'b00 |=> jump_o; endproperty
    a_jmp: assert property (p_jmp) else $error("no frame jump");
    property p_pop;
        acc && w[47:40] == 8'h08 |=> loop_pop_o == $past(w[38] & cond_true_i)
            && pcstk_pop_o == loop_pop_o;
    endproperty
    a_pop: assert property (p_pop) else $error("bad pop");
    property p_clr;
        acc && w[47:40] == 8'h08 |=> clr_int_o == $past(w[37] & cond_true_i);
    endproperty
    a_clr: assert property (p_clr) else $error("bad clear");
    property p_imm;
        acc && w[47:40] == 8'h06 |=> imm_valid_o
            && imm12_o == {$past(w[35:32]), $past(w[7:0])};
    endproperty
    a_imm: assert property (p_imm) else $error("bad imm");
    // codes 011, 110 and 111 must come out flagged as not legal
    property p_bitsel;
        acc && w[47:40] == 8'h12 |=> bitop_o.valid
            && bitop_o.legal == !($past(w[38:37]) == 2'b11 || $past(w[39:38]) == 2'b11)
            && (!bitop_o.legal || bitop_o.op == $past(w[39:37]));
    endproperty
    a_bitsel: assert property (p_bitsel) else $error("bad bitop");
endmodule
bind mid_core mid_core_props mid_core_props_i (.*);

// ---- mid_dmem_model.sv ----
// Purpose: data memory answering frame restore reads
// Assumes: one read outstanding
// Notes: answers address plus 0x100 after DLY cycles
module mid_dmem_model #(parameter int DLY = 3) (
    input wire logic clk_i,
    input wire logic dm_rd_i,
    input wire logic [31:0] dm_addr_i,
    output logic [31:0] dm_rdata_o = 32'h0,
    output logic dm_rvalid_o = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    logic [31:0] adr = 32'h0;
    // slow answer; data churns outside it so stale data equals the last answer only every other cycle
    always @(posedge clk_i)
    begin
        cnt <= dm_rd_i ? DLY : (cnt > 0 ? cnt - 1 : 0);
        if (dm_rd_i)
            adr <= dm_addr_i;
        dm_rvalid_o <= cnt == 1;
        dm_rdata_o <= (cnt == 1) ? adr + 32'h100 : ~dm_rdata_o;
    end
endmodule

// ---- misc_instruction_decode_tb.sv ----
// Purpose: self-checking bench of the misc decoder
// Assumes: effects one cycle after accept
// Notes: frame restore data comes from the slow memory model
module misc_instruction_decode_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, dm_rdata_i, dm_addr_o, rd;
    logic wb_ack_o, instr_valid_i = 1'b0, instr_ready_o, instr_short_space_i = 1'b0;
    logic [47:0] instr_word_i = 48'h0;
    logic [1:0] instr_size_i = 2'h0;
    logic cond_true_i = 1'b0, irq_i = 1'b0, jump_o, loop_pop_o, pcstk_pop_o, clr_int_o;
    logic irq_ack_o, low_power_o, emu_space_o, imm_valid_o, dm_rd_o, dm_rvalid_i;
    logic [23:0] fetch_addr_o, p;
    logic [11:0] imm12_o;
    mid_pkg::mid_bitop_t bitop_o;
    int error_cnt = 0, checks_done = 0;
    // ----------------
    // clock, design and memory
    // ----------------
    always #4 clk_i = ~clk_i;
    mid_core mid_core_i (.*);
    mid_dmem_model mid_dmem_model_i (.clk_i(clk_i), .dm_rd_i(dm_rd_o), .dm_addr_i(dm_addr_o),
        .dm_rdata_o(dm_rdata_i), .dm_rvalid_o(dm_rvalid_i));
    task automatic print_verdict();
        if (error_cnt == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // bounded wait, levels sampled at the edge
    task automatic wait_hi(ref logic s);
        int n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (s !== 1'b1 && n < 50);
        if (s !== 1'b1)
        begin
            error_cnt++;
            print_verdict();
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wait_hi(wb_ack_o);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic ins(input logic [47:0] w, input logic c = 1'b0, input logic sh = 1'b0,
        input logic [1:0] sz = 2'h0);
        @(posedge clk_i);
        instr_valid_i <= 1'b1;
        instr_word_i <= w;
        cond_true_i <= c;
        instr_short_space_i <= sh;
        instr_size_i <= sz;
        wait_hi(instr_ready_o);
        instr_valid_i <= 1'b0;
        #1;
    endtask
    // ----------------
    // scenarios
    // ----------------
    task automatic t_nop();
        logic [47:0] wv [4] = '{48'h150000000000, 48'h150000000000, 48'h000015000000, 48'h000000001500};
        logic [23:0] st [4] = '{24'h1, 24'h3, 24'h2, 24'h1};
        for (int i = 0; i < 4; i++)
        begin
            p = fetch_addr_o;
            ins(wv[i], 1'b0, i != 0, i == 0 ? 2'h0 : 2'(i - 1));
            chk({jump_o, fetch_addr_o}, {1'b0, p + st[i]});
        end
    endtask
    task automatic t_dec();
        logic [2:0] ops [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
        ins(48'h060a0000005c);
        chk({imm_valid_o, imm12_o}, {1'b1, 12'ha5c});
        foreach (ops[i])
        begin
            ins({8'h12, ops[i], 4'h3, 1'b0, 32'h00000070});
            chk(bitop_o, {1'b1, 1'b1, ops[i], 4'h3, 32'h00000070});
        end
        ins({8'h12, 3'h6, 4'h3, 1'b0, 32'h00000070});
        chk(bitop_o.legal, 1'b0);
        for (int i = 0; i < 8; i++)
        begin
            ins({8'h08, 1'b0, i[1], i[2], 13'h0, 24'h000100}, i[0]);
            chk({loop_pop_o, pcstk_pop_o, clr_int_o}, {{2{i[1] & i[0]}}, i[2] & i[0]});
        end
    endtask
    task automatic t_frame();
        wb(1'b1, mid_pkg::MID_ADR_CTRL, 32'h1);
        wb(1'b1, mid_pkg::MID_ADR_FRAME_INDEX, 32'h30);
        wb(1'b1, mid_pkg::MID_ADR_STACK_INDEX, 32'h50);
        ins(48'h190000000200);
        chk(jump_o, 1'b1);
        ins(48'h150000000000);
        ins(48'h150000000000);
        chk(fetch_addr_o, 24'h000200);
        rdchk(mid_pkg::MID_ADR_X_DATA_REG_TWO, 32'h30);
        rdchk(mid_pkg::MID_ADR_Y_DATA_REG_TWO, 32'h30);
        rdchk(mid_pkg::MID_ADR_FRAME_INDEX, 32'h50);
        p = fetch_addr_o;
        ins(48'h190400fffff0);
        ins(48'h150000000000);
        ins(48'h150000000000);
        chk(fetch_addr_o, p - 24'h000010);
        wb(1'b1, mid_pkg::MID_ADR_FRAME_INDEX, 32'h70);
        ins(48'h190800000000);
        chk({dm_rd_o, dm_addr_o}, {1'b1, 32'h70});
        wait_hi(dm_rvalid_i);
        rdchk(mid_pkg::MID_ADR_STACK_INDEX, 32'h70);
        rdchk(mid_pkg::MID_ADR_FRAME_INDEX, 32'h170);
        wb(1'b1, mid_pkg::MID_ADR_CTRL, 32'h0);
        ins(48'h190000000300);
        ins(48'h150000000000);
        ins(48'h150000000000);
        chk(fetch_addr_o, 24'h000300);
        rdchk(mid_pkg::MID_ADR_X_DATA_REG_TWO, 32'h170);
        rdchk(mid_pkg::MID_ADR_Y_DATA_REG_TWO, 32'h50);
        ins(48'h000000001900, 1'b0, 1'b1, 2'h2);
        chk({dm_rd_o, dm_addr_o}, {1'b1, 32'h70});
        wait_hi(dm_rvalid_i);
        rdchk(mid_pkg::MID_ADR_STACK_INDEX, 32'h70);
        rdchk(mid_pkg::MID_ADR_FRAME_INDEX, 32'h170);
    endtask
    task automatic t_idle();
        ins(48'h168000000000);
        p = fetch_addr_o;
        repeat (5) @(posedge clk_i);
        chk({low_power_o, instr_ready_o}, 2'b10);
        irq_i <= 1'b1;
        @(posedge clk_i);
        irq_i <= 1'b0;
        #1;
        chk({low_power_o, irq_ack_o}, 2'b01);
        ins(48'h0a0000000000);
        chk({clr_int_o, fetch_addr_o}, {1'b0, p});
        ins(48'h160000000000);
        chk({emu_space_o, low_power_o}, 2'b10);
        rdchk(mid_pkg::MID_ADR_STATUS, 32'h2);
        ins(48'h0a2000000000);
        chk({emu_space_o, clr_int_o}, 2'b01);
    endtask
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_nop();
        t_dec();
        t_frame();
        t_nop();
        t_idle();
        print_verdict();
    end
endmodule
